// >>> hw/icc_regs.svh
`ifndef ICC_REGS_SVH
`define ICC_REGS_SVH
`define ICC_CTRL_ADDR    8'h05
`define ICC_CTRL_RESET   8'h0f
`define ICC_ACK_BIT      7
`define ICC_SEL_BIT      6
`define ICC_IEN_BIT      5
`define ICC_PEND_BIT     4
`define ICC_PRE_MSB      3
`define ICC_PRE_LSB      0
`define ICC_DIV_FAST     10'd16
`define ICC_DIV_SLOW     10'd512
`endif

// >>> hw/icc_pkg.sv
package icc_pkg;
   typedef logic [7:0] icc_byte_t;
   typedef logic [9:0] icc_cnt_t;
endpackage : icc_pkg

// >>> hw/icc_clock_control.sv
`include "icc_regs.svh"
module icc_clock_control
   import icc_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      rstn,
   input  wire logic      reg_sel,
   input  wire logic      reg_wr,
   input  wire icc_byte_t reg_addr,
   input  wire icc_byte_t reg_wdata,
   output icc_byte_t      reg_rdata,
   input  wire logic      byte_done,
   output logic           ack_enable,
   output logic           bus_clock_base,
   output logic           scl_tick,
   output logic           irq
);
   // ************************************************
   // decode helpers
   // ************************************************
   // one address compare shared by the write strobe and the read mux
   function automatic logic ctrl_hit(input icc_byte_t addr);
      return addr == `ICC_CTRL_ADDR;
   endfunction : ctrl_hit

   function automatic logic [3:0] pre_field(input icc_byte_t val);
      return val[`ICC_PRE_MSB:`ICC_PRE_LSB];
   endfunction : pre_field

   // ************************************************
   // control register
   // ************************************************
   icc_byte_t ctrl_q, ctrl_d;
   logic      hit_wr;
   assign hit_wr = reg_sel && reg_wr && ctrl_hit(reg_addr);

   always_comb begin
      ctrl_d = ctrl_q;
      if (hit_wr) begin
         ctrl_d = reg_wdata;
         // writing 1 cannot create a request; only 0 clears it
         ctrl_d[`ICC_PEND_BIT] = ctrl_q[`ICC_PEND_BIT] & reg_wdata[`ICC_PEND_BIT];
      end
      if (byte_done) begin
         ctrl_d[`ICC_PEND_BIT] = 1'b1; // set wins over clear
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ctrl_q <= `ICC_CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   always_comb begin
      reg_rdata = 8'h00;
      if (reg_sel && ctrl_hit(reg_addr)) begin
         reg_rdata = ctrl_q;
      end
   end

   assign ack_enable = ctrl_q[`ICC_ACK_BIT];
   assign irq        = ctrl_q[`ICC_PEND_BIT] & ctrl_q[`ICC_IEN_BIT];

   // ************************************************
   // clock dividers
   // ************************************************
   icc_cnt_t  base_cnt_q, base_cnt_d;
   logic [3:0] pre_cnt_q, pre_cnt_d;
   logic      base_q, base_d, tick_q, tick_d;
   icc_cnt_t  base_div;
   assign base_div = ctrl_q[`ICC_SEL_BIT] ? `ICC_DIV_SLOW : `ICC_DIV_FAST;

   always_comb begin
      base_cnt_d = base_cnt_q + 10'd1;
      base_d     = 1'b0;
      pre_cnt_d  = pre_cnt_q;
      tick_d     = 1'b0;
      // a shrunk divisor restarts the count rather than wrapping through 1023
      if (base_cnt_q >= base_div - 10'd1) begin
         base_cnt_d = 10'd0;
         base_d     = 1'b1;
         if (pre_cnt_q >= pre_field(ctrl_q)) begin
            pre_cnt_d = 4'h0;
            tick_d    = 1'b1;
         end else begin
            pre_cnt_d = pre_cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         base_cnt_q <= 10'd0;
         pre_cnt_q  <= 4'h0;
         base_q     <= 1'b0;
         tick_q     <= 1'b0;
      end else begin
         base_cnt_q <= base_cnt_d;
         pre_cnt_q  <= pre_cnt_d;
         base_q     <= base_d;
         tick_q     <= tick_d;
      end
   end

   assign bus_clock_base = base_q;
   assign scl_tick       = tick_q;

   // ************************************************
   // assertion helpers
   // ************************************************
   // counters stand in for long repetitions, which the tools would unroll
   icc_cnt_t   gap_q, gap_d;
   logic       gap_clean_q, gap_clean_d;
   logic [4:0] seen_q, seen_d;
   logic       seen_clean_q, seen_clean_d;

   always_comb begin
      gap_d        = gap_q;
      gap_clean_d  = gap_clean_q & ~hit_wr;
      seen_d       = seen_q;
      seen_clean_d = seen_clean_q & ~hit_wr;
      if (base_q) begin
         gap_d       = 10'h000;
         gap_clean_d = ~hit_wr;
      end else if (gap_q != 10'h3ff) begin
         gap_d = gap_q + 10'h001;
      end
      if (tick_q) begin
         seen_d       = 5'h00;
         seen_clean_d = ~hit_wr;
      end else if (base_q && (seen_q != 5'h1f)) begin
         seen_d = seen_q + 5'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         gap_q        <= 10'h000;
         gap_clean_q  <= 1'b0;
         seen_q       <= 5'h00;
         seen_clean_q <= 1'b0;
      end else begin
         gap_q        <= gap_d;
         gap_clean_q  <= gap_clean_d;
         seen_q       <= seen_d;
         seen_clean_q <= seen_clean_d;
      end
   end

   // ************************************************
   // assertions
   // ************************************************
   sequence s_clear_write;
      hit_wr && !reg_wdata[`ICC_PEND_BIT] && !byte_done;
   endsequence
   sequence s_byte_end;
      byte_done;
   endsequence
   sequence s_pend_low;
      !ctrl_q[`ICC_PEND_BIT];
   endsequence

   a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
      irq == (ctrl_q[`ICC_IEN_BIT] & ctrl_q[`ICC_PEND_BIT]))
      else $error("irq not pending and enable");
   a_ien_map: assert property (@(posedge clk_sys) disable iff (!rstn)
      hit_wr |=> ctrl_q[`ICC_IEN_BIT] == $past(reg_wdata[`ICC_IEN_BIT]))
      else $error("interrupt enable not written");
   a_pend_set: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_byte_end |=> ctrl_q[`ICC_PEND_BIT])
      else $error("pending not set");
   a_pend_clr: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_clear_write |=> s_pend_low)
      else $error("pending not cleared");
   a_pend_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
      !ctrl_q[`ICC_PEND_BIT] && !byte_done |=> s_pend_low)
      else $error("pending rose by itself");
   a_pend_wr1: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_pend_low ##0 (hit_wr && reg_wdata[`ICC_PEND_BIT] && !byte_done) |=> s_pend_low)
      else $error("write of one set pending");
   a_rd_ctrl: assert property (@(posedge clk_sys) disable iff (!rstn)
      reg_sel && (reg_addr == `ICC_CTRL_ADDR) |-> reg_rdata == ctrl_q)
      else $error("control read wrong");
   a_rd_other: assert property (@(posedge clk_sys) disable iff (!rstn)
      reg_sel && (reg_addr != `ICC_CTRL_ADDR) |-> reg_rdata == 8'h00)
      else $error("other address read not zero");

   a_ack_map: assert property (@(posedge clk_sys) disable iff (!rstn)
      hit_wr |=> ack_enable == $past(reg_wdata[`ICC_ACK_BIT]))
      else $error("ack enable wrong");
   a_ack_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
      !hit_wr |=> $stable(ack_enable))
      else $error("ack enable moved without write");

   a_sel_map: assert property (@(posedge clk_sys) disable iff (!rstn)
      hit_wr |=> ctrl_q[`ICC_SEL_BIT] == $past(reg_wdata[`ICC_SEL_BIT]))
      else $error("clock select not written");
   a_fast_base: assert property (@(posedge clk_sys) disable iff (!rstn)
      base_q && gap_clean_q && !ctrl_q[`ICC_SEL_BIT] |-> gap_q == `ICC_DIV_FAST - 10'h001)
      else $error("fast base period wrong");
   a_slow_base: assert property (@(posedge clk_sys) disable iff (!rstn)
      base_q && gap_clean_q && ctrl_q[`ICC_SEL_BIT] |-> gap_q == `ICC_DIV_SLOW - 10'h001)
      else $error("slow base period wrong");
   a_fast_gap: assert property (@(posedge clk_sys) disable iff (!rstn)
      base_q && !ctrl_q[`ICC_SEL_BIT] |=> !base_q[*8])
      else $error("base too frequent");
   a_base_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
      base_q |=> !base_q)
      else $error("base pulse longer than one cycle");

   a_pre_map: assert property (@(posedge clk_sys) disable iff (!rstn)
      hit_wr |=> ctrl_q[`ICC_PRE_MSB:`ICC_PRE_LSB] == $past(reg_wdata[`ICC_PRE_MSB:`ICC_PRE_LSB]))
      else $error("prescaler not written");
   a_tick_base: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick_q |-> base_q)
      else $error("tick off base edge");
   a_tick_div1: assert property (@(posedge clk_sys) disable iff (!rstn)
      base_q && ctrl_q[`ICC_PRE_MSB:`ICC_PRE_LSB] == 4'h0 && pre_cnt_q == 4'h0 |-> tick_q)
      else $error("divide by one missed");
   a_tick_period: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick_q && seen_clean_q |-> seen_q == {1'b0, ctrl_q[`ICC_PRE_MSB:`ICC_PRE_LSB]})
      else $error("tick not every prescaler plus one base pulses");
   a_tick_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick_q |=> !tick_q)
      else $error("tick pulse longer than one cycle");
endmodule : icc_clock_control

// >>> test/icc_bus_partner.sv
module icc_bus_partner (
   input  wire logic clk_sys,
   input  wire logic go,
   output logic      byte_done
);
   timeunit 1ns;
   timeprecision 1ps;
   // one pulse per byte finished on the wire
   initial begin
      byte_done = 1'b0;
      forever @(negedge clk_sys) byte_done <= go;
   end
endmodule : icc_bus_partner

// >>> test/icc_clock_control_tb.sv
module icc_clock_control_tb import icc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic      clk_sys = 1'b0, rstn = 1'b0, sel = 1'b0, wr = 1'b0, go = 1'b0;
   icc_byte_t adr = 8'h00, wd = 8'h00, rd;
   logic      ack, base, tick, irq, done;
   int        failures = 0, checks = 0, n;
   always #2 clk_sys = ~clk_sys;
   icc_bus_partner icc_bus_partner_inst (.clk_sys(clk_sys), .go(go), .byte_done(done));
   icc_clock_control icc_clock_control_inst (.clk_sys(clk_sys), .rstn(rstn), .reg_sel(sel), .reg_wr(wr),
      .reg_addr(adr), .reg_wdata(wd), .reg_rdata(rd), .byte_done(done), .ack_enable(ack),
      .bus_clock_base(base), .scl_tick(tick), .irq(irq));
   task automatic cmp(string nm, logic [9:0] exp, logic [9:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : cmp
   task automatic wr_reg(icc_byte_t a, icc_byte_t d);
      @(negedge clk_sys) {sel, wr, adr, wd} = {2'b11, a, d};
      @(negedge clk_sys) {sel, wr} = 2'b00;
   endtask : wr_reg
   task automatic rd_reg(icc_byte_t a, icc_byte_t exp);
      @(negedge clk_sys) {sel, adr} = {1'b1, a};
      #1 cmp("reg_rdata", {2'b00, exp}, {2'b00, rd});
   endtask : rd_reg
   task automatic test_done();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   // skip two pulses first: counters may sit past the new divisor
   task automatic period(string nm, bit use_base, int exp);
      repeat (2) do @(negedge clk_sys); while ((use_base ? base : tick) !== 1'b1);
      n = 0;
      do begin @(negedge clk_sys); n++; end while ((use_base ? base : tick) !== 1'b1);
      cmp(nm, exp[9:0], n[9:0]);
   endtask : period
   initial begin
      #100us failures++;
      test_done();
   end
   initial begin
      repeat (8) @(negedge clk_sys);
      rstn = 1'b1;
      rd_reg(8'h05, 8'h0f);
      cmp("ack_enable", 10'h000, {9'h000, ack});
      wr_reg(8'h05, 8'hb0);
      rd_reg(8'h05, 8'ha0);
      cmp("ack_enable", 10'h001, {9'h000, ack});
      cmp("irq", 10'h000, {9'h000, irq});
      @(negedge clk_sys) go <= 1'b1;
      @(negedge clk_sys) go <= 1'b0;
      @(negedge clk_sys) cmp("irq", 10'h001, {9'h000, irq});
      rd_reg(8'h05, 8'hb0);
      wr_reg(8'h05, 8'h90);
      cmp("irq", 10'h000, {9'h000, irq});
      wr_reg(8'h05, 8'h00);
      rd_reg(8'h05, 8'h00);
      @(negedge clk_sys) go <= 1'b1;
      @(negedge clk_sys) go <= 1'b0;
      {sel, wr, adr, wd} = {2'b11, 8'h05, 8'h80};
      @(negedge clk_sys) {sel, wr} = 2'b00;
      rd_reg(8'h05, 8'h90);
      cmp("irq", 10'h000, {9'h000, irq});
      rd_reg(8'h06, 8'h00);
      $display("test registers done");
      wr_reg(8'h05, 8'h00);
      period("scl_tick period", 1'b0, 16);
      wr_reg(8'h05, 8'h0f);
      period("bus_clock_base period", 1'b1, 16);
      period("scl_tick period", 1'b0, 256);
      wr_reg(8'h05, 8'h40);
      period("bus_clock_base period", 1'b1, 512);
      period("scl_tick period", 1'b0, 512);
      $display("test clock done");
      test_done();
   end
endmodule : icc_clock_control_tb
